// *** src/shreg_pkg.sv ***
// shared types, constants and next-state decode for the five-stage shift register
package shreg_pkg;

  // ----------------------------------------------------------------------------
  // sizes, reset values, encodings
  // ----------------------------------------------------------------------------
  localparam int unsigned STAGES     = 5;
  localparam int unsigned SYNC_DEPTH = 2;     // flops ahead of any pin reader
  localparam int unsigned BUF_DEPTH  = 2;     // entries in the output skid buffer
  localparam logic [4:0]  STAGE_RST  = 5'h00;
  localparam logic        MODE_SHIFT = 1'h0;
  localparam logic        MODE_LOAD  = 1'h1;
  localparam logic        FLAG_CLR   = 1'h0;
  localparam logic        PIN_RST    = 1'h0;

  typedef logic [STAGES-1:0] stage_t;         // bit 0 is the first stage

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_PEND = 2'h2
  } core_st_t;

  // pin group as it arrives from the surrounding logic
  typedef struct packed {
    logic   clr_n;                            // clear, active low
    logic   mode;                             // low: shift right, high: parallel load
    logic   ser;                              // serial data into the first stage
    logic   tclk;                             // shift clock, acts on its falling edge
    stage_t par;                              // parallel data, bit 0 to first stage
  } pins_t;

  // word handed downstream after each shift or load
  typedef struct packed {
    logic   mode;
    stage_t data;
  } word_t;

  // ----------------------------------------------------------------------------
  // next contents of the stages for one shift or one load
  // ----------------------------------------------------------------------------
  function automatic stage_t next_stage(input logic mode, input logic ser,
                                        input stage_t par, input stage_t cur);
    stage_t nxt;
    nxt = (mode == MODE_LOAD) ? par : {cur[STAGES-2:0], ser};
    return nxt;
  endfunction

endpackage

// *** src/shreg_skid_buf.sv ***
// two-entry skid buffer between the stage register and the downstream reader
`timescale 1ns/1ns
module shreg_skid_buf
  import shreg_pkg::*;
(
  input  wire logic  i_clk,                   // core clock
  input  wire logic  i_rst_n,                 // async reset, active low
  input  wire logic  i_ce,                    // clock enable, freezes all state
  input  wire logic  i_flush,                 // drops both entries
  input  wire word_t i_data,                  // word to store
  input  wire logic  i_valid,                 // i_data is offered
  output logic       o_ready,                 // a word can be taken
  output word_t      o_data,                  // head word, from a flop
  output logic       o_valid,                 // head word is present
  input  wire logic  i_ready                  // reader takes the head word
);

  word_t skid_q;
  logic  skid_v_q;
  logic  push;
  logic  pop;

  assign push = i_valid && o_ready;
  assign pop  = o_valid && i_ready;

  // ----------------------------------------------------------------------------
  // head entry
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data  <= '0;
      o_valid <= 1'h0;
    end else if (i_ce) begin
      if (i_flush) begin
        o_valid <= 1'h0;
      end else if (!o_valid || pop) begin
        if (skid_v_q) begin
          o_data  <= skid_q;
          o_valid <= 1'h1;
        end else if (push) begin
          o_data  <= i_data;
          o_valid <= 1'h1;
        end else begin
          o_valid <= 1'h0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // second entry; only fills while the head is held by the reader
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      skid_q   <= '0;
      skid_v_q <= 1'h0;
      o_ready  <= 1'h1;
    end else if (i_ce) begin
      if (i_flush) begin
        skid_v_q <= 1'h0;
        o_ready  <= 1'h1;
      end else if (skid_v_q && (!o_valid || pop)) begin
        skid_v_q <= 1'h0;
        o_ready  <= 1'h1;
      end else if (push && o_valid && !pop) begin
        skid_q   <= i_data;
        skid_v_q <= 1'h1;
        o_ready  <= 1'h0;
      end
    end
  end

endmodule // shreg_skid_buf

// *** src/shift5_core.sv ***
// five-stage right-shift / parallel-load register with clear, driven from pins
//
// Functional notes
// - five storage stages are shown on five parallel outputs, first to last stage.
// - with mode low each active clock edge shifts right, serial input entering stage one; here a fall arriving while one is held is dropped.
// - with mode high one active clock edge copies the five parallel inputs into the stages.
// - shifting or loading happens only when the shift clock falls from high to low.
// - while clear is low all five outputs are held low whatever the other inputs do; here clear has no effect while I_CE is low.
// - a right shift puts the serial level in stage one and each stage's old level in the next.
// - on a load each stage takes the steady level of its parallel input.
`timescale 1ns/1ns
module shift5_core
  import shreg_pkg::*;
(
  input  wire logic          I_CORE_CLK,      // 25 MHz core clock
  input  wire logic          I_RESETN,        // async reset, active low
  input  wire logic          I_CE,            // clock enable, freezes all state when low
  input  wire shreg_pkg::pins_t I_PINS,       // raw pin group from outside
  input  wire logic          I_RD_READY,      // downstream takes O_WORD
  output shreg_pkg::stage_t  O_STAGE,         // stage contents, bit 0 first stage
  output shreg_pkg::word_t   O_WORD,          // buffered word after each applied edge, none for a dropped one
  output logic               O_WORD_VALID,    // O_WORD present
  output logic               O_BUSY,          // an edge waits for buffer room
  output logic               O_OVERRUN        // an edge was dropped, sticky until clear
);

  import shreg_pkg::*;

  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  pins_t    pin_s1_q;
  pins_t    pin_s2_q;
  logic     tclk_prev_q;
  logic     fall;
  logic     clr_on;

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      pin_s1_q    <= '0;
      pin_s2_q    <= '0;
      tclk_prev_q <= PIN_RST;
    end else if (I_CE) begin
      pin_s1_q    <= I_PINS;
      pin_s2_q    <= pin_s1_q;
      tclk_prev_q <= pin_s2_q.tclk;
    end
  end

  // pin clock is far slower than the core clock, so sampling loses no edge
  assign fall   = tclk_prev_q && !pin_s2_q.tclk;
  // synchronised clear lands two cycles after the pin; reset must cover start-up
  assign clr_on = !pin_s2_q.clr_n;

  // ----------------------------------------------------------------------------
  // edge capture and stall against the buffer
  // ----------------------------------------------------------------------------
  core_st_t st_q;
  logic     pend_mode_q;
  logic     pend_ser_q;
  stage_t   pend_par_q;
  logic     buf_ready;
  logic     apply;
  logic     use_mode;
  logic     use_ser;
  stage_t   use_par;
  stage_t   nxt_stage;
  word_t    push_word;

  // data levels are taken together with the edge that moves them
  always_comb begin
    use_mode = pin_s2_q.mode;
    use_ser  = pin_s2_q.ser;
    use_par  = pin_s2_q.par;
    apply    = 1'h0;
    unique case (st_q)
      ST_IDLE: apply = fall && buf_ready;
      ST_PEND: begin
        use_mode = pend_mode_q;
        use_ser  = pend_ser_q;
        use_par  = pend_par_q;
        apply    = buf_ready;
      end
      default: apply = 1'h0;
    endcase
    apply = apply && I_CE && !clr_on;
  end

  assign nxt_stage = next_stage(use_mode, use_ser, use_par, O_STAGE);
  assign push_word = '{mode: use_mode, data: nxt_stage};

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      st_q        <= ST_IDLE;
      pend_mode_q <= MODE_SHIFT;
      pend_ser_q  <= 1'h0;
      pend_par_q  <= STAGE_RST;
    end else if (I_CE) begin
      if (clr_on) begin
        st_q <= ST_IDLE;
      end else begin
        unique case (st_q)
          ST_IDLE: if (fall && !buf_ready) begin
            st_q        <= ST_PEND;
            pend_mode_q <= pin_s2_q.mode;
            pend_ser_q  <= pin_s2_q.ser;
            pend_par_q  <= pin_s2_q.par;
          end
          ST_PEND: if (buf_ready) begin
            st_q <= ST_IDLE;
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // stage register and status
  // ----------------------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_STAGE <= STAGE_RST;
    end else if (I_CE) begin
      if (clr_on) begin
        O_STAGE <= STAGE_RST;
      end else if (apply) begin
        O_STAGE <= nxt_stage;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_BUSY    <= 1'h0;
      O_OVERRUN <= FLAG_CLR;
    end else if (I_CE) begin
      O_BUSY <= !clr_on && ((st_q == ST_IDLE && fall && !buf_ready) ||
                            (st_q == ST_PEND && !buf_ready));
      if (!clr_on && st_q == ST_PEND && fall) begin
        O_OVERRUN <= 1'h1;
      end else if (clr_on) begin
        O_OVERRUN <= FLAG_CLR;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // output buffer, flushed by clear
  // ----------------------------------------------------------------------------
  shreg_skid_buf u_buf (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RESETN),
    .i_ce    (I_CE),
    .i_flush (clr_on),
    .i_data  (push_word),
    .i_valid (apply),
    .o_ready (buf_ready),
    .o_data  (O_WORD),
    .o_valid (O_WORD_VALID),
    .i_ready (I_RD_READY)
  );

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESETN);

  chk_stage_update: assert property (apply |=> O_STAGE == $past(nxt_stage))
    else $error("stage register did not take the computed value");

  chk_right_shift: assert property (
    apply && use_mode == MODE_SHIFT |=> O_STAGE[0] == $past(use_ser))
    else $error("first stage did not take the serial level");

  chk_par_load: assert property (
    apply && use_mode == MODE_LOAD |=> O_STAGE == $past(use_par))
    else $error("parallel load did not copy the inputs");

  chk_load_steady: assert property (
    I_CE && !clr_on && st_q == ST_IDLE && fall && buf_ready && pin_s2_q.mode
    |=> O_STAGE == $past(pin_s2_q.par))
    else $error("loaded stages differ from the parallel levels at the edge");

  chk_edge_apply: assert property (
    I_CE && !clr_on && st_q == ST_IDLE && fall && buf_ready |=> O_WORD_VALID && !O_BUSY)
    else $error("falling shift clock did not pass a word downstream");

  chk_stall_hold: assert property (
    I_CE && !clr_on && st_q == ST_IDLE && fall && !buf_ready
    |=> O_BUSY && st_q == ST_PEND ##[1:300] (apply || clr_on || !I_CE))
    else $error("stalled edge was not kept or not resolved");

  // a held edge has no second slot, so a further fall must be reported, not queued
  chk_overrun_set: assert property (
    I_CE && !clr_on && st_q == ST_PEND && fall && !buf_ready |=> O_OVERRUN && O_BUSY)
    else $error("edge arriving while one is held did not raise overrun");

  chk_clear_force: assert property (
    I_CE && clr_on |=> O_STAGE == STAGE_RST && !O_WORD_VALID)
    else $error("clear did not force the outputs low");

  chk_clear_hold: assert property (
    (I_CE && clr_on) [*3] |=> O_STAGE == STAGE_RST && !O_BUSY)
    else $error("outputs moved while clear was held");

  chk_no_edge_keep: assert property (!apply && !clr_on |=> $stable(O_STAGE))
    else $error("stages changed without an active edge");

  for (genvar k = 1; k < STAGES; k++) begin : g_chain
    chk_shift_chain: assert property (
      apply && use_mode == MODE_SHIFT |=> O_STAGE[k] == $past(O_STAGE[k-1]))
      else $error("stage did not take its predecessor's old level");
  end

  cov_shift: cover property (apply && use_mode == MODE_SHIFT);
  cov_load: cover property (apply && use_mode == MODE_LOAD);
  cov_stall: cover property (st_q == ST_PEND ##[1:20] apply);
  cov_clear: cover property (O_STAGE != STAGE_RST ##1 clr_on);

endmodule // shift5_core

// *** bench/pin_model.sv ***
// surrounding logic that drives the shift register's pin group
`timescale 1ns/1ns
module pin_model
  import shreg_pkg::*;
(
  input  wire logic   i_clk,    // core clock, pins change on its falling edge
  input  wire stage_t i_stage,  // stage outputs, fed back for left shifting
  output pins_t       o_pins    // pin group towards the register
);
  import shreg_pkg::*;

  // ----------------------------------------------------------------------------
  // pin state
  // ----------------------------------------------------------------------------
  pins_t p   = '{clr_n: 1'h1, mode: MODE_SHIFT, ser: 1'h0, tclk: 1'h0, par: 5'h00};
  logic  lft = 1'h0;

  // left shift: mode high, serial into last stage, each output into the stage before
  assign o_pins = '{clr_n: p.clr_n, mode: p.mode, ser: p.ser, tclk: p.tclk,
                    par: lft ? {p.ser, i_stage[4:1]} : p.par};

  // ----------------------------------------------------------------------------
  // pin sequences; data settle well ahead of the clock fall and stay after it
  // ----------------------------------------------------------------------------
  task automatic setup(input logic m, input logic s, input stage_t d, input logic l);
    @(negedge i_clk);
    p.mode = m;
    p.ser  = s;
    p.par  = d;
    lft    = l;
    repeat (4) @(negedge i_clk);
  endtask

  task automatic up();
    p.tclk = 1'h1;
    repeat (8) @(negedge i_clk);
  endtask

  task automatic down();
    p.tclk = 1'h0;
    repeat (8) @(negedge i_clk);
  endtask

  task automatic pulse(input logic m, input logic s, input stage_t d, input logic l);
    setup(m, s, d, l);
    up();
    down();
  endtask

  task automatic clr(input logic v);
    @(negedge i_clk);
    p.clr_n = v;
    repeat (6) @(negedge i_clk);
  endtask
endmodule // pin_model

// *** bench/tb_top.sv ***
// self-checking bench for the five-stage shift register
`timescale 1ns/1ns
module tb_top;
  import shreg_pkg::*;

  logic   core_clk = 1'h0;
  logic   resetn   = 1'h0;
  logic   ce       = 1'h1;
  logic   rd_rdy   = 1'h1;
  pins_t  pins;
  stage_t stage;
  word_t  word;
  logic   word_vld;
  logic   busy;
  logic   ovr;
  stage_t exp_q    = 5'h00;
  int     error_cnt    = 0;
  int     total_checks = 0;

  always #20 core_clk = ~core_clk;

  pin_model u_pins (.i_clk(core_clk), .i_stage(stage), .o_pins(pins));

  shift5_core u_dut (.I_CORE_CLK(core_clk), .I_RESETN(resetn), .I_CE(ce), .I_PINS(pins),
    .I_RD_READY(rd_rdy), .O_STAGE(stage), .O_WORD(word), .O_WORD_VALID(word_vld),
    .O_BUSY(busy), .O_OVERRUN(ovr));

  // ----------------------------------------------------------------------------
  // shared checking and closing
  // ----------------------------------------------------------------------------
  task automatic chk(input string what, input logic [5:0] seen, input logic [5:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_shift();
    logic [4:0] bits = 5'h0D;
    for (int i = 0; i < 5; i++) begin
      u_pins.pulse(MODE_SHIFT, bits[i], 5'h1F, 1'h0);
      exp_q = {exp_q[3:0], bits[i]};
      chk("shift stage", {1'h0, stage}, {1'h0, exp_q});
    end
    $display("test shift done");
  endtask

  task automatic t_load();
    stage_t tbl [4] = '{5'h15, 5'h0A, 5'h1F, 5'h00};
    foreach (tbl[i]) begin
      u_pins.pulse(MODE_LOAD, ~tbl[i][0], tbl[i], 1'h0);
      exp_q = tbl[i];
      chk("load stage", {1'h0, stage}, {1'h0, exp_q});
    end
    $display("test load done");
  endtask

  task automatic t_left();
    logic [3:0] bits = 4'hD;
    u_pins.pulse(MODE_LOAD, 1'h0, 5'h03, 1'h0);
    exp_q = 5'h03;
    for (int i = 0; i < 4; i++) begin
      u_pins.pulse(MODE_LOAD, bits[i], 5'h00, 1'h1);
      exp_q = {bits[i], exp_q[4:1]};
      chk("left stage", {1'h0, stage}, {1'h0, exp_q});
    end
    $display("test left done");
  endtask

  task automatic t_hold();
    u_pins.setup(MODE_LOAD, 1'h1, 5'h1B, 1'h0);
    u_pins.up();
    chk("rise ignored", {1'h0, stage}, {1'h0, exp_q});
    u_pins.down();
    exp_q = 5'h1B;
    chk("fall acts", {1'h0, stage}, {1'h0, exp_q});
    u_pins.setup(MODE_SHIFT, 1'h0, 5'h04, 1'h0);
    repeat (12) @(negedge core_clk);
    chk("no edge hold", {1'h0, stage}, {1'h0, exp_q});
    ce = 1'h0;
    u_pins.pulse(MODE_LOAD, 1'h0, 5'h0A, 1'h0);
    ce = 1'h1;
    repeat (6) @(negedge core_clk);
    chk("frozen hold", {1'h0, stage}, {1'h0, exp_q});
    $display("test hold done");
  endtask

  task automatic t_clear();
    rd_rdy = 1'h0;
    u_pins.pulse(MODE_LOAD, 1'h0, 5'h15, 1'h0);
    chk("word held", {5'h00, word_vld}, 6'h01);
    u_pins.clr(1'h0);
    chk("clear stage", {1'h0, stage}, 6'h00);
    chk("clear valid", {5'h00, word_vld}, 6'h00);
    rd_rdy = 1'h1;
    u_pins.pulse(MODE_LOAD, 1'h1, 5'h1F, 1'h0);
    chk("clear wins", {1'h0, stage}, 6'h00);
    u_pins.clr(1'h1);
    exp_q = 5'h00;
    $display("test clear done");
  endtask

  task automatic take(input word_t exp);
    for (int n = 0; n < 40 && word_vld !== 1'h1; n++) @(negedge core_clk);
    chk("word out", word, exp);
    rd_rdy = 1'h1;
    @(negedge core_clk);
    rd_rdy = 1'h0;
    @(negedge core_clk);
  endtask

  task automatic t_stall();
    rd_rdy = 1'h0;
    u_pins.pulse(MODE_LOAD, 1'h0, 5'h11, 1'h0);
    u_pins.pulse(MODE_LOAD, 1'h0, 5'h06, 1'h0);
    u_pins.pulse(MODE_LOAD, 1'h0, 5'h19, 1'h0);
    chk("busy held", {5'h00, busy}, 6'h01);
    chk("stage waits", {1'h0, stage}, 6'h06);
    u_pins.pulse(MODE_LOAD, 1'h0, 5'h02, 1'h0);
    chk("overrun", {5'h00, ovr}, 6'h01);
    take({MODE_LOAD, 5'h11});
    take({MODE_LOAD, 5'h06});
    take({MODE_LOAD, 5'h19});
    chk("stage late", {1'h0, stage}, 6'h19);
    chk("drained", {5'h00, word_vld}, 6'h00);
    u_pins.clr(1'h0);
    chk("overrun cleared", {5'h00, ovr}, 6'h00);
    u_pins.clr(1'h1);
    rd_rdy = 1'h1;
    exp_q = 5'h00;
    $display("test stall done");
  endtask

  // ----------------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------------
  initial begin
    repeat (2) @(negedge core_clk);
    resetn = 1'h1;
    repeat (4) @(negedge core_clk);
    chk("reset stage", {1'h0, stage}, 6'h00);
    chk("reset flags", {3'h0, word_vld, busy, ovr}, 6'h00);
    t_shift();
    t_load();
    t_left();
    t_hold();
    t_clear();
    t_stall();
    close_out();
  end

  // about 22 pin pulses of some 21 cycles each, with ample margin
  initial begin
    repeat (6000) @(posedge core_clk);
    error_cnt++;
    $display("watchdog expired");
    close_out();
  end
endmodule // tb_top
